// [rtl/acl_defs.vh]
`ifndef ACL_DEFS_VH
`define ACL_DEFS_VH

// Clock rate and timing
`define ACL_CLK_MHZ        100
`define ACL_DELAY_MAX_US   8000
`define ACL_IFRST_NS       40
`define ACL_IFRST_CYC      ((`ACL_IFRST_NS * `ACL_CLK_MHZ) / 1000)

// Register addresses
`define ACL_ADDR_STATUS    6'h00
`define ACL_ADDR_ADCMODE   6'h01
`define ACL_ADDR_IFMODE    6'h02
`define ACL_ADDR_REGCHECK  6'h03
`define ACL_ADDR_DATA      6'h04
`define ACL_ADDR_PINIO     6'h06
`define ACL_ADDR_ID        6'h07

// Reset values
`define ACL_ADCMODE_RST    16'h2000
`define ACL_IFMODE_RST     16'h0000
`define ACL_PINIO_RST      16'h0800
`define ACL_ID_VALUE       16'h5a50

// Command byte
`define ACL_CMD_WEN        7
`define ACL_CMD_RW         6

// conversion_mode_control fields
`define ACL_AM_DLY_HI      10
`define ACL_AM_DLY_LO      8

// interface_mode_control fields
`define ACL_IF_SHORT_WORD_SELECT        0
`define ACL_IF_CRC_HI      3
`define ACL_IF_CRC_LO      2
`define ACL_IF_REGCHK      5
`define ACL_IF_DSTAT       6
`define ACL_IF_DOUTRST     8
`define ACL_IF_HIDE        10
`define ACL_IF_ALTSYNC     12

// pin_io_control fields
`define ACL_PC_DATA0       0
`define ACL_PC_DATA1       1
`define ACL_PC_OPEN0       2
`define ACL_PC_OPEN1       3
`define ACL_PC_IPEN0       4
`define ACL_PC_IPEN1       5
`define ACL_PC_DATA2       6
`define ACL_PC_DATA3       7
`define ACL_PC_ERRDAT      8
`define ACL_PC_ERREN_HI    10
`define ACL_PC_ERREN_LO    9
`define ACL_PC_SYNCEN      11
`define ACL_PC_MUXIO       12
`define ACL_PC_OPEN23      13

// Error pin modes
`define ACL_ERR_OFF        2'b00
`define ACL_ERR_IN         2'b01
`define ACL_ERR_OD         2'b10
`define ACL_ERR_GPO        2'b11

// Checksum polynomial x8+x2+x+1
`define ACL_CRC_POLY       8'h07

`endif

// [rtl/acl_sync2.v]
`timescale 1ns/1ns
module acl_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= {W{1'b1}};
      q_o      <= {W{1'b1}};
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// [rtl/acl_aux_ctrl.v]
`timescale 1ns/1ns
`include "acl_defs.vh"
module acl_aux_ctrl #(
  parameter DELAY_MAX_US = `ACL_DELAY_MAX_US
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  // Serial port
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire        din_i,
  output reg         dout_rdy_o,
  // Sync pin
  input  wire        sync_n_i,
  // General pins
  input  wire [1:0]  pin_in_i,
  output reg  [1:0]  pin_out_o,
  output reg  [1:0]  pin_oe_o,
  output reg  [1:0]  pin23_out_o,
  output reg         pin23_oe_o,
  // Error pin
  input  wire        err_n_in_i,
  output reg         err_n_out_o,
  output reg         err_n_oe_o,
  // Converter core
  input  wire [15:0] ch_en_i,
  input  wire        absorb_ok_i,
  input  wire [19:0] conv_half_cyc_i,
  input  wire        conv_done_i,
  input  wire [23:0] conv_result_i,
  input  wire        conv_over_i,
  input  wire        conv_under_i,
  output reg         filter_rst_o,
  output reg         conv_start_o,
  output reg         absorb_o,
  output reg  [3:0]  channel_o
);
  localparam integer DLY_MAX_RAW = DELAY_MAX_US * `ACL_CLK_MHZ;
  localparam integer IFRST_RAW   = (`ACL_IFRST_CYC < 1) ? 1 : `ACL_IFRST_CYC;
  localparam [19:0] DLY_MAX_CYC = DLY_MAX_RAW[19:0];
  localparam [2:0]  IFRST_CYC   = IFRST_RAW[2:0];
  localparam [1:0] P_CMD = 2'd0, P_DATA = 2'd1, P_CRC = 2'd2, P_DONE = 2'd3;
  localparam [1:0] S_IDLE = 2'd0, S_DELAY = 2'd1, S_CONV = 2'd2, S_WAIT = 2'd3;

  function [4:0] next_ch;
    input [15:0] mask;
    input [3:0]  cur;
    input        first;
    integer      k;
    reg   [4:0]  idx;
    begin
      next_ch = {1'b0, cur};
      for (k = 16; k >= 1; k = k - 1) begin
        idx = first ? (k[4:0] - 5'd1) : ({1'b0, cur} + k[4:0]);
        if (mask[idx[3:0]])
          next_ch = {1'b0, idx[3:0]};
      end
    end
  endfunction

  function [5:0] spi_len;
    input [5:0] addr;
    input       short_word_select;
    input       dstat;
    begin
      case (addr)
        `ACL_ADDR_STATUS:   spi_len = 6'd8;
        `ACL_ADDR_REGCHECK: spi_len = 6'd24;
        `ACL_ADDR_DATA:     spi_len = (short_word_select ? 6'd16 : 6'd24) + (dstat ? 6'd8 : 6'd0);
        default:            spi_len = 6'd16;
      endcase
    end
  endfunction

  wire       cs_s, sclk_s, din_s, sync_s, err_s;
  wire [1:0] pin_s;
  acl_sync2 #(.W(7)) u_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    ({cs_n_i, sclk_i, din_i, sync_n_i, err_n_in_i, pin_in_i}),
    .q_o    ({cs_s, sclk_s, din_s, sync_s, err_s, pin_s})
  );

  reg [15:0] adcmode_reg, ifmode_reg, pinio_reg;
  reg [1:0]  phase_reg;
  reg [5:0]  cnt_reg, len_reg;
  reg [7:0]  cmd_reg, crc_reg;
  reg [23:0] wsh_reg;
  reg [31:0] sh_reg;
  reg [2:0]  tmr_reg;
  reg        sclk_d_reg, sync_d_reg;
  reg        crc_bad_reg, rd_status_reg, rd_data_reg;
  reg        rdy_n_reg, adc_cond_reg, crc_err_reg, reg_err_reg, alt_pend_reg;
  reg [23:0] data_reg;
  reg [3:0]  data_ch_reg;
  reg [7:0]  sum_ref_reg;
  reg [1:0]  st_reg;
  reg [19:0] dcnt_reg;

  wire       sclk_rise = sclk_s & ~sclk_d_reg;
  wire       sclk_fall = ~sclk_s & sclk_d_reg;
  wire [1:0] err_mode  = pinio_reg[`ACL_PC_ERREN_HI:`ACL_PC_ERREN_LO];
  wire       short_word_select      = ifmode_reg[`ACL_IF_SHORT_WORD_SELECT];
  wire       dstat     = ifmode_reg[`ACL_IF_DSTAT];
  wire       sync_en   = pinio_reg[`ACL_PC_SYNCEN];
  wire       alt_mode  = sync_en & ifmode_reg[`ACL_IF_ALTSYNC];
  wire [7:0] cmd_nxt   = {cmd_reg[6:0], din_s};
  wire [7:0] crc_nxt   = {crc_reg[6:0], 1'b0} ^ ((crc_reg[7] ^ din_s) ? `ACL_CRC_POLY : 8'h00);
  wire [7:0] reg_sum   = adcmode_reg[15:8] ^ adcmode_reg[7:0] ^ pinio_reg[15:8] ^ pinio_reg[7:0];

  wire       adc_err  = adc_cond_reg | ((err_mode == `ACL_ERR_IN) & ~err_s);
  wire [7:0] status   = {rdy_n_reg, adc_err, crc_err_reg, reg_err_reg, data_ch_reg};

  reg [15:0] pinio_rd;
  reg [31:0] rd_val;
  always @* begin
    pinio_rd = pinio_reg;
    if (pinio_reg[`ACL_PC_IPEN0])
      pinio_rd[`ACL_PC_DATA0] = pin_s[0];
    if (pinio_reg[`ACL_PC_IPEN1])
      pinio_rd[`ACL_PC_DATA1] = pin_s[1];
    if (err_mode == `ACL_ERR_IN)
      pinio_rd[`ACL_PC_ERRDAT] = err_s;
    case (cmd_nxt[5:0])
      `ACL_ADDR_STATUS:   rd_val = {24'h000000, status};
      `ACL_ADDR_ADCMODE:  rd_val = {16'h0000, adcmode_reg};
      `ACL_ADDR_IFMODE:   rd_val = {16'h0000, ifmode_reg};
      `ACL_ADDR_REGCHECK: rd_val = {24'h000000, sum_ref_reg};
      `ACL_ADDR_PINIO:    rd_val = {16'h0000, pinio_rd};
      `ACL_ADDR_ID:       rd_val = {16'h0000, `ACL_ID_VALUE};
      `ACL_ADDR_DATA:     rd_val = short_word_select ? (dstat ? {8'h00, data_reg[23:8], status} : {16'h0000, data_reg[23:8]})
                                        : (dstat ? {data_reg, status} : {8'h00, data_reg});
      default:            rd_val = 32'h00000000;
    endcase
  end

  // Serial interface
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg     <= P_CMD;
      cnt_reg       <= 6'd0;
      len_reg       <= 6'd0;
      cmd_reg       <= 8'h00;
      crc_reg       <= 8'h00;
      wsh_reg       <= 24'h000000;
      sh_reg        <= 32'h00000000;
      tmr_reg       <= 3'd0;
      sclk_d_reg    <= 1'b1;
      dout_rdy_o    <= 1'b1;
      crc_bad_reg   <= 1'b0;
      rd_status_reg <= 1'b0;
      rd_data_reg   <= 1'b0;
      adcmode_reg   <= `ACL_ADCMODE_RST;
      ifmode_reg    <= `ACL_IFMODE_RST;
      pinio_reg     <= `ACL_PINIO_RST;
    end else begin
      sclk_d_reg    <= sclk_s;
      crc_bad_reg   <= 1'b0;
      rd_status_reg <= 1'b0;
      rd_data_reg   <= 1'b0;
      if (cs_s) begin
        phase_reg  <= P_CMD;
        cnt_reg    <= 6'd0;
        crc_reg    <= 8'h00;
        tmr_reg    <= 3'd0;
        dout_rdy_o <= 1'b1;
      end else if (tmr_reg != 3'd0) begin
        tmr_reg <= tmr_reg - 3'd1;
        if (tmr_reg == 3'd1) begin
          phase_reg <= P_CMD;
          cnt_reg   <= 6'd0;
          crc_reg   <= 8'h00;
        end
      end else begin
        if (phase_reg == P_CMD)
          dout_rdy_o <= rdy_n_reg;
        if (sclk_fall && phase_reg == P_DATA && cmd_reg[`ACL_CMD_RW]) begin
          dout_rdy_o <= sh_reg[31];
          sh_reg     <= {sh_reg[30:0], 1'b0};
        end
        if (sclk_rise) begin
          case (phase_reg)
            P_CMD: begin
              cmd_reg <= cmd_nxt;
              crc_reg <= crc_nxt;
              cnt_reg <= cnt_reg + 6'd1;
              if (cnt_reg == 6'd7) begin
                cnt_reg <= 6'd0;
                len_reg <= spi_len(cmd_nxt[5:0], short_word_select, dstat);
                sh_reg  <= rd_val << (6'd32 - spi_len(cmd_nxt[5:0], short_word_select, dstat));
                if (cmd_nxt[`ACL_CMD_WEN])
                  crc_reg <= 8'h00;
                else
                  phase_reg <= P_DATA;
              end
            end
            P_DATA: begin
              wsh_reg <= {wsh_reg[22:0], din_s};
              crc_reg <= crc_nxt;
              cnt_reg <= cnt_reg + 6'd1;
              if (cnt_reg == len_reg - 6'd1) begin
                cnt_reg <= 6'd0;
                if (cmd_reg[`ACL_CMD_RW]) begin
                  phase_reg     <= P_DONE;
                  rd_status_reg <= (cmd_reg[5:0] == `ACL_ADDR_STATUS);
                  rd_data_reg   <= (cmd_reg[5:0] == `ACL_ADDR_DATA);
                  if (!ifmode_reg[`ACL_IF_DOUTRST])
                    tmr_reg <= IFRST_CYC;
                end else if (ifmode_reg[`ACL_IF_CRC_HI:`ACL_IF_CRC_LO] != 2'b00) begin
                  phase_reg <= P_CRC;
                end else begin
                  phase_reg <= P_CMD;
                  crc_reg   <= 8'h00;
                  case (cmd_reg[5:0])
                    `ACL_ADDR_ADCMODE: adcmode_reg <= {wsh_reg[14:0], din_s};
                    `ACL_ADDR_IFMODE:  ifmode_reg  <= {wsh_reg[14:0], din_s};
                    `ACL_ADDR_PINIO:   pinio_reg   <= {wsh_reg[14:0], din_s};
                    default:           pinio_reg   <= pinio_reg;
                  endcase
                end
              end
            end
            P_CRC: begin
              crc_reg <= crc_nxt;
              cnt_reg <= cnt_reg + 6'd1;
              if (cnt_reg == 6'd7) begin
                cnt_reg   <= 6'd0;
                phase_reg <= P_CMD;
                crc_reg   <= 8'h00;
                if (crc_nxt != 8'h00)
                  crc_bad_reg <= 1'b1;
                else begin
                  case (cmd_reg[5:0])
                    `ACL_ADDR_ADCMODE: adcmode_reg <= wsh_reg[15:0];
                    `ACL_ADDR_IFMODE:  ifmode_reg  <= wsh_reg[15:0];
                    `ACL_ADDR_PINIO:   pinio_reg   <= wsh_reg[15:0];
                    default:           pinio_reg   <= pinio_reg;
                  endcase
                end
              end
            end
            default: phase_reg <= phase_reg;
          endcase
        end
      end
    end
  end

  // Error flags
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crc_err_reg <= 1'b0;
      reg_err_reg <= 1'b0;
      sum_ref_reg <= 8'h00;
    end else begin
      if (crc_bad_reg)
        crc_err_reg <= 1'b1;
      else if (rd_status_reg)
        crc_err_reg <= 1'b0;
      if (!ifmode_reg[`ACL_IF_REGCHK]) begin
        sum_ref_reg <= reg_sum;
        reg_err_reg <= 1'b0;
      end else if (reg_sum != sum_ref_reg)
        reg_err_reg <= 1'b1;
    end
  end

  // Conversion sequencing
  wire [19:0] dly_cyc  = (adcmode_reg[`ACL_AM_DLY_HI:`ACL_AM_DLY_LO] == 3'd0) ? 20'd0 :
                         (DLY_MAX_CYC >> (3'd7 - adcmode_reg[`ACL_AM_DLY_HI:`ACL_AM_DLY_LO]));
  wire        dly_wait = (dly_cyc != 20'd0) &&
                         (ifmode_reg[`ACL_IF_HIDE] || !(absorb_ok_i && dly_cyc < conv_half_cyc_i));
  wire        hold     = sync_en & ~alt_mode & ~sync_s;
  wire [4:0]  ch_next  = next_ch(ch_en_i, channel_o, 1'b0);
  wire [4:0]  ch_first = next_ch(ch_en_i, channel_o, 1'b1);
  wire [23:0] rnd16    = (conv_result_i[23:8] == 16'hffff) ? 24'hffff00 :
                         {conv_result_i[23:8] + {15'h0000, conv_result_i[7]}, 8'h00};

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg       <= S_IDLE;
      dcnt_reg     <= 20'd0;
      filter_rst_o <= 1'b1;
      conv_start_o <= 1'b0;
      absorb_o     <= 1'b0;
      channel_o    <= 4'h0;
      sync_d_reg   <= 1'b1;
      alt_pend_reg <= 1'b0;
      rdy_n_reg    <= 1'b1;
      adc_cond_reg <= 1'b0;
      data_reg     <= 24'h000000;
      data_ch_reg  <= 4'h0;
    end else begin
      sync_d_reg   <= sync_s;
      conv_start_o <= 1'b0;
      filter_rst_o <= 1'b0;
      if (rd_data_reg)
        rdy_n_reg <= 1'b1;
      if (alt_mode && sync_d_reg && !sync_s)
        alt_pend_reg <= 1'b1;
      // Also parks on a disabled channel, as after reset
      if (hold || !ch_en_i[channel_o]) begin
        st_reg       <= S_IDLE;
        filter_rst_o <= 1'b1;
        channel_o    <= ch_first[3:0];
        alt_pend_reg <= 1'b0;
      end else begin
        case (st_reg)
          S_IDLE, S_WAIT: begin
            if (st_reg == S_IDLE || sync_s) begin
              absorb_o <= (dly_cyc != 20'd0) && !dly_wait;
              dcnt_reg <= dly_cyc;
              if (dly_wait)
                st_reg <= S_DELAY;
              else begin
                st_reg       <= S_CONV;
                conv_start_o <= 1'b1;
              end
            end
          end
          S_DELAY: begin
            dcnt_reg <= dcnt_reg - 20'd1;
            if (dcnt_reg == 20'd1) begin
              st_reg       <= S_CONV;
              conv_start_o <= 1'b1;
            end
          end
          S_CONV: begin
            if (conv_done_i) begin
              adc_cond_reg <= conv_over_i | conv_under_i;
              data_reg     <= conv_over_i ? 24'hffffff : conv_under_i ? 24'h000000 :
                              short_word_select ? rnd16 : conv_result_i;
              data_ch_reg  <= channel_o;
              rdy_n_reg    <= 1'b0;
              channel_o    <= ch_next[3:0];
              if (alt_pend_reg) begin
                alt_pend_reg <= 1'b0;
                st_reg       <= S_WAIT;
              end else
                st_reg <= S_IDLE;
            end
          end
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end

  // Pin drivers
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_out_o   <= 2'b00;
      pin_oe_o    <= 2'b00;
      pin23_out_o <= 2'b00;
      pin23_oe_o  <= 1'b0;
      err_n_out_o <= 1'b1;
      err_n_oe_o  <= 1'b0;
    end else begin
      if (!pinio_reg[`ACL_PC_MUXIO] || conv_start_o) begin
        pin_out_o   <= {pinio_reg[`ACL_PC_DATA1], pinio_reg[`ACL_PC_DATA0]};
        pin23_out_o <= {pinio_reg[`ACL_PC_DATA3], pinio_reg[`ACL_PC_DATA2]};
      end
      pin_oe_o   <= {pinio_reg[`ACL_PC_OPEN1], pinio_reg[`ACL_PC_OPEN0]};
      pin23_oe_o <= pinio_reg[`ACL_PC_OPEN23];
      case (err_mode)
        `ACL_ERR_GPO: begin
          err_n_out_o <= pinio_reg[`ACL_PC_ERRDAT];
          err_n_oe_o  <= 1'b1;
        end
        `ACL_ERR_OD: begin
          err_n_out_o <= 1'b0;
          err_n_oe_o  <= adc_err | crc_err_reg | reg_err_reg;
        end
        default: begin
          err_n_out_o <= 1'b1;
          err_n_oe_o  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// [testbench/acl_aux_ctrl_monitor.sv]
`timescale 1ns/1ns
module acl_aux_ctrl_monitor (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  // Pins
  input wire logic        cs_n_i,
  input wire logic        sync_n_i,
  input wire logic        dout_rdy_o,
  // Converter core
  input wire logic [15:0] ch_en_i,
  input wire logic        conv_done_i,
  input wire logic        filter_rst_o,
  input wire logic        conv_start_o,
  input wire logic [3:0]  channel_o
);
  reg [4:0] low_hist;

  // Recent low samples of the sync pin
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      low_hist <= 5'h00;
    else
      low_hist <= {low_hist[3:0], ~sync_n_i};
  end

  function automatic [3:0] first_ch(input [15:0] m);
    integer i;
    begin
      first_ch = 4'h0;
      for (i = 15; i >= 0; i = i - 1)
        if (m[i])
          first_ch = i[3:0];
    end
  endfunction

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_sync_held;
    !sync_n_i [*5];
  endsequence
  sequence s_sync_up;
    $rose(sync_n_i) && ch_en_i != 16'h0000;
  endsequence

  a_dout_idle_high: assert property (cs_n_i [*4] |-> dout_rdy_o)
    else $error("dout not high while deselected");
  a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  a_no_start_rst: assert property (filter_rst_o |-> !conv_start_o)
    else $error("start while filter held in reset");
  a_filt_cause: assert property ($rose(filter_rst_o) |-> (|low_hist) || ch_en_i == 16'h0000)
    else $error("filter reset without sync low");
  a_filt_hold: assert property (s_sync_held |-> filter_rst_o)
    else $error("filter not held while sync low");
  a_chan_first: assert property (s_sync_held |-> channel_o == first_ch(ch_en_i))
    else $error("channel not first enabled during sync");
  a_filt_release: assert property (s_sync_up ##0 filter_rst_o |-> ##[1:6] !filter_rst_o)
    else $error("filter not released after sync rise");
  a_chan_moves: assert property (!$stable(channel_o) |->
    $past(conv_done_i) || $past(conv_done_i, 2) || filter_rst_o || $past(filter_rst_o))
    else $error("channel changed without a conversion end");
endmodule

// [testbench/acl_host_model.sv]
`timescale 1ns/1ns
module acl_host_model #(
  parameter LAT = 30
) (
  // Clock
  input  wire        clk_i,
  // Serial port
  input  wire        dout_i,
  output reg         cs_n_o,
  output reg         sclk_o,
  output reg         din_o,
  // Converter core
  input  wire        start_i,
  output reg         done_o,
  output reg  [23:0] result_o,
  output reg         over_o,
  output reg         under_o
);
  reg [23:0] res;
  reg        ovr;
  reg        unr;
  integer    cnt;
  integer    age;
  integer    gap;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
    done_o = 1'b0;
    result_o = 24'h000000;
    over_o = 1'b0;
    under_o = 1'b0;
    unr = 1'b0;
    res = 24'h123456;
    ovr = 1'b0;
    cnt = 0;
    age = 0;
    gap = 0;
  end

  always @(negedge clk_i) begin
    done_o <= 1'b0;
    result_o <= ~result_o;
    age <= age + 1;
    if (start_i) begin
      cnt <= LAT;
      gap <= age;
      age <= 0;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      result_o <= res;
      over_o <= ovr;
      under_o <= unr;
      cnt <= 0;
    end else if (cnt > 1)
      cnt <= cnt - 1;
  end

  // Clock idles high; data changes on falls, sampled before rises
  task xfer(input [7:0] cmd, input [31:0] wd, input integer n, output [31:0] rd);
    integer b;
    begin
      rd = 32'h0;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (b = 0; b < 8 + n; b = b + 1) begin
        repeat (4) @(negedge clk_i);
        sclk_o = 1'b0;
        din_o = (b < 8) ? cmd[7 - b] : wd[n + 7 - b];
        repeat (4) @(negedge clk_i);
        if (b >= 8)
          rd = {rd[30:0], dout_i};
        sclk_o = 1'b1;
      end
      repeat (6) @(negedge clk_i);
      cs_n_o = 1'b1;
      din_o = ~din_o;
      repeat (10) @(negedge clk_i);
    end
  endtask
endmodule

// [testbench/acl_aux_ctrl_test.sv]
`timescale 1ns/1ns
`include "acl_defs.vh"
module acl_aux_ctrl_test;
  reg         clk_sys_i;
  reg         rstn_i;
  reg         sync_n_i;
  reg  [1:0]  pin_ext;
  reg         err_ext;
  reg  [15:0] ch_en_i;
  reg         absorb_ok_i;
  reg  [19:0] conv_half_cyc_i;
  wire        cs_n_i, sclk_i, din_i, dout_rdy_o, conv_done_i, conv_over_i, conv_under_i;
  wire [1:0]  pin_in_i, pin_out_o, pin_oe_o, pin23_out_o;
  wire        pin23_oe_o, err_n_in_i, err_n_out_o, err_n_oe_o, filter_rst_o, conv_start_o, absorb_o;
  wire [23:0] conv_result_i;
  wire [3:0]  channel_o;
  integer     err_total;
  integer     checks;
  reg  [31:0] rv;

  // Pin levels seen from all drivers
  assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & pin_ext);
  assign err_n_in_i = err_n_oe_o ? err_n_out_o : err_ext;

  acl_aux_ctrl #(.DELAY_MAX_US(8)) uut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .din_i(din_i),
    .dout_rdy_o(dout_rdy_o), .sync_n_i(sync_n_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .pin23_out_o(pin23_out_o), .pin23_oe_o(pin23_oe_o), .err_n_in_i(err_n_in_i),
    .err_n_out_o(err_n_out_o), .err_n_oe_o(err_n_oe_o), .ch_en_i(ch_en_i), .absorb_ok_i(absorb_ok_i),
    .conv_half_cyc_i(conv_half_cyc_i), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .conv_over_i(conv_over_i), .conv_under_i(conv_under_i), .filter_rst_o(filter_rst_o),
    .conv_start_o(conv_start_o), .absorb_o(absorb_o), .channel_o(channel_o));

  acl_host_model #(.LAT(30)) p (
    .clk_i(clk_sys_i), .dout_i(dout_rdy_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i),
    .start_i(conv_start_o), .done_o(conv_done_i), .result_o(conv_result_i), .over_o(conv_over_i),
    .under_o(conv_under_i));

  always #5 clk_sys_i = ~clk_sys_i;

  function [7:0] crc8(input [23:0] v);
    integer i;
    begin
      crc8 = 8'h00;
      for (i = 23; i >= 0; i = i - 1)
        crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ v[i]) ? 8'h07 : 8'h00);
    end
  endfunction

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [5:0] a, input [15:0] v);
    p.xfer({2'b00, a}, {16'h0000, v}, 16, rv);
  endtask

  task rdr(input [5:0] a, input integer n);
    p.xfer({2'b01, a}, 32'h0, n, rv);
  endtask

  task t_reset;
    begin
      rdr(`ACL_ADDR_ADCMODE, 16);
      chk("mode reg", 32'h2000, rv);
      rdr(`ACL_ADDR_IFMODE, 16);
      chk("if reg", 32'h0000, rv);
      rdr(`ACL_ADDR_PINIO, 16);
      chk("pin reg", 32'h0800, rv);
      chk("pin enables", 32'h0, {err_n_oe_o, pin23_oe_o, pin_oe_o});
      $display("test reset done");
    end
  endtask

  task t_pins;
    begin
      pin_ext = 2'b10;
      wr(`ACL_ADDR_PINIO, 16'h28a5);
      chk("pin oe", 32'h1, pin_oe_o);
      chk("pin0 out", 32'h1, pin_out_o[0]);
      chk("pins23", 32'h6, {pin23_oe_o, pin23_out_o});
      rdr(`ACL_ADDR_PINIO, 16);
      chk("pin1 high", 32'h1, rv[1]);
      pin_ext = 2'b00;
      rdr(`ACL_ADDR_PINIO, 16);
      chk("pin1 low", 32'h0, rv[1]);
      $display("test pins done");
    end
  endtask

  task t_errpin;
    begin
      wr(`ACL_ADDR_PINIO, 16'h0800);
      chk("err off", 32'h0, err_n_oe_o);
      wr(`ACL_ADDR_PINIO, 16'h0f00);
      chk("err gpo high", 32'h3, {err_n_oe_o, err_n_out_o});
      wr(`ACL_ADDR_PINIO, 16'h0e00);
      chk("err gpo low", 32'h2, {err_n_oe_o, err_n_out_o});
      err_ext = 1'b0;
      wr(`ACL_ADDR_PINIO, 16'h0a00);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("err input flag", 32'h1, rv[6]);
      rdr(`ACL_ADDR_PINIO, 16);
      chk("err level low", 32'h0, rv[8]);
      err_ext = 1'b1;
      rdr(`ACL_ADDR_PINIO, 16);
      chk("err level high", 32'h1, rv[8]);
      $display("test error pin done");
    end
  endtask

  task t_crc;
    begin
      wr(`ACL_ADDR_PINIO, 16'h0c00);
      repeat (100) @(negedge clk_sys_i);
      chk("od idle", 32'h0, err_n_oe_o);
      wr(`ACL_ADDR_IFMODE, 16'h0004);
      p.xfer(8'h06, {8'h00, 16'h0f00, crc8({8'h06, 16'h0f00}) ^ 8'hff}, 24, rv);
      chk("od active", 32'h2, {err_n_oe_o, err_n_out_o});
      rdr(`ACL_ADDR_PINIO, 16);
      chk("bad write dropped", 32'h0c00, rv);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("crc flag set", 32'h1, rv[5]);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("crc flag clear", 32'h0, rv[5]);
      chk("od released", 32'h0, err_n_oe_o);
      p.xfer(8'h02, {8'h00, 16'h0000, crc8({8'h02, 16'h0000})}, 24, rv);
      wr(`ACL_ADDR_IFMODE, 16'h0020);
      wr(`ACL_ADDR_PINIO, 16'h0c01);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("reg flag set", 32'h1, rv[4]);
      wr(`ACL_ADDR_IFMODE, 16'h0000);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("reg flag clear", 32'h0, rv[4]);
      $display("test checksum done");
    end
  endtask

  task t_data;
    begin
      rdr(`ACL_ADDR_DATA, 24);
      chk("data 24", 32'h123456, rv);
      p.ovr = 1'b1;
      repeat (100) @(negedge clk_sys_i);
      rdr(`ACL_ADDR_DATA, 24);
      chk("data over", 32'hffffff, rv);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("range flag kept", 32'h1, rv[6]);
      p.ovr = 1'b0;
      p.unr = 1'b1;
      repeat (100) @(negedge clk_sys_i);
      rdr(`ACL_ADDR_DATA, 24);
      chk("data under", 32'h0, rv);
      p.unr = 1'b0;
      repeat (100) @(negedge clk_sys_i);
      rdr(`ACL_ADDR_STATUS, 8);
      chk("range flag gone", 32'h0, rv[6]);
      wr(`ACL_ADDR_IFMODE, 16'h0041);
      repeat (100) @(negedge clk_sys_i);
      rdr(`ACL_ADDR_DATA, 24);
      chk("data 16", 32'h1234, rv[23:8]);
      chk("status chan", 32'h1, rv[3:0] === 4'h2 || rv[3:0] === 4'h4);
      wr(`ACL_ADDR_IFMODE, 16'h0000);
      repeat (100) @(negedge clk_sys_i);
      rdr(`ACL_ADDR_DATA, 24);
      chk("data back 24", 32'h123456, rv);
      $display("test data done");
    end
  endtask

  task t_sync;
    begin
      wr(`ACL_ADDR_PINIO, 16'h1805);
      repeat (40) @(negedge clk_sys_i);
      sync_n_i = 1'b0;
      wr(`ACL_ADDR_PINIO, 16'h1804);
      chk("mux pin held", 32'h1, pin_out_o[0]);
      chk("sync hold", 32'h12, {filter_rst_o, channel_o});
      sync_n_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      chk("sync release", 32'h0, filter_rst_o);
      chk("mux pin moved", 32'h0, pin_out_o[0]);
      $display("test sync done");
    end
  endtask

  task t_alt;
    begin
      wr(`ACL_ADDR_IFMODE, 16'h1000);
      // two channels enabled; one device, edge timing free
      sync_n_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk("alt no reset", 32'h0, filter_rst_o);
      sync_n_i = 1'b1;
      repeat (100) @(negedge clk_sys_i);
      chk("alt resumes", 32'h1, p.age < 40);
      $display("test alternate_sync_select done");
    end
  endtask

  task t_delay;
    begin
      wr(`ACL_ADDR_ADCMODE, 16'h2700);
      wr(`ACL_ADDR_IFMODE, 16'h0400);
      repeat (2000) @(negedge clk_sys_i);
      chk("delay added", 32'h1, p.gap > 800);
      wr(`ACL_ADDR_IFMODE, 16'h0000);
      absorb_ok_i = 1'b1;
      repeat (2000) @(negedge clk_sys_i);
      chk("absorb on", 32'h3, {absorb_o, p.gap < 800});
      absorb_ok_i = 1'b0;
      repeat (2000) @(negedge clk_sys_i);
      chk("absorb off", 32'h1, {absorb_o, p.gap > 800});
      $display("test delay done");
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    clk_sys_i = 1'b0;
    rstn_i = 1'b0;
    sync_n_i = 1'b1;
    pin_ext = 2'b00;
    err_ext = 1'b1;
    ch_en_i = 16'h0014;
    absorb_ok_i = 1'b0;
    conv_half_cyc_i = 20'd1000;
    err_total = 0;
    checks = 0;
    repeat (8) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    t_reset;
    t_pins;
    t_errpin;
    t_crc;
    t_data;
    t_sync;
    t_alt;
    t_delay;
    complete_run;
  end

  initial begin
    #400000;
    err_total = err_total + 1;
    $display("watchdog expired");
    complete_run;
  end
endmodule

bind acl_aux_ctrl acl_aux_ctrl_monitor mon (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sync_n_i(sync_n_i), .dout_rdy_o(dout_rdy_o),
  .ch_en_i(ch_en_i), .conv_done_i(conv_done_i), .filter_rst_o(filter_rst_o), .conv_start_o(conv_start_o),
  .channel_o(channel_o));
